// ### hw/chop_polarity.sv
// reference chop polarity sequencer
`timescale 1ns/1ns
module chop_polarity
    import metering_cfg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sync_pulse,
    input  wire logic       sum_end,
    input  chop_mode_t      mode,
    output logic            polarity,
    output logic            alt_frame
);

    logic sync_d_r;
    logic sync_rise;

    assign sync_rise = sync_pulse & ~sync_d_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= sync_pulse;
        end
    end

    // polarity moves on sync rising edge only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            polarity <= 1'b0;
        end else if (sync_rise) begin
            case (mode)
                CHOP_TOGGLE_ALT: begin
                    if (!sum_end) begin
                        polarity <= ~polarity;
                    end
                end
                CHOP_POSITIVE: polarity <= 1'b0;
                CHOP_REVERSED: polarity <= 1'b1;
                CHOP_TOGGLE:   polarity <= ~polarity;
                default:       polarity <= polarity;
            endcase
        end
    end

    // extra alternative frame at end of accumulation
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alt_frame <= 1'b0;
        end else begin
            alt_frame <= sync_rise & sum_end
                         & (mode == CHOP_TOGGLE_ALT);
        end
    end

endmodule : chop_polarity

// ### hw/metering_config_bits.sv
// metering configuration register bank
//
// Operation
// - write-only bits always read back zero
// - nonvolatile bits untouched by wake
// - display bits survive display-brownout, lost sleeping
// - converter enable powers converter and reference
// - battery measure loads battery, routes to converter on alt mux cycles
// - boot region ends at 1024 times size
// - engine clock 10 MHz set, 5 MHz clear
// - engine program starts 1024 times location
// - polarity changes only on sync rising edge
// - mode 00 toggles, skips summation end, inserts frame
// - 01 positive, 10 reversed, 11 plain toggle
// - channel chop needs own and common enable
// - shared pin: segment at 0, filter clock at 1
// - reset and wake load listed values
`timescale 1ns/1ns
module metering_config_bits
    import metering_cfg_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input  wire logic                CORE_CLK,
    input  wire logic                RESET_N,
    input  wire logic                WAKE,
    input  wire logic [1:0]          POWER_MODE,
    input  wire logic [ADDR_W-1:0]   CFG_ADDR,
    input  wire logic [DATA_W-1:0]   CFG_WDATA,
    input  wire logic                CFG_WR,
    input  wire logic                CFG_RD,
    input  wire logic                MULTIPLEXER_SYNC_PULSE,
    input  wire logic                SUMMATION_CYCLE_END,
    input  wire logic                ALT_MUX_CYCLE,
    input  wire logic                DISPLAY_SEGMENT_NINETEEN,
    output logic [DATA_W-1:0]        CFG_RDATA,
    output logic                     CONVERTER_ENABLE,
    output logic                     REFERENCE_ENABLE,
    output logic                     BATTERY_LOAD,
    output logic                     BATTERY_TO_CONVERTER,
    output logic [17:0]              BOOT_END_ADDR,
    output logic [14:0]              ENGINE_PROG_START,
    output logic                     ENGINE_ENABLE,
    output logic                     ENGINE_CLK_TICK,
    output logic                     REF_POLARITY,
    output logic                     ALTERNATIVE_FRAME_REQUEST,
    output logic                     CURRENT_A_SWAP,
    output logic                     CURRENT_B_SWAP,
    output logic                     SHARED_PIN_OUT
);

    // address match helper
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [15:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    // clear write-only bits on read
    function automatic logic [7:0] rd_view(input logic [7:0] v,
                                           input logic [7:0] wo);
        rd_view = v & ~wo;
    endfunction : rd_view

    cfg_access_t  acc;
    cfg_t         cfg_r;
    cfg_t         cfg_nxt;
    power_mode_t  pm;
    power_mode_t  pm_prev_r;
    logic         enter_sleep;
    logic [7:0]   rdata_nxt;
    logic [1:0]   eng_cnt_r;
    logic [1:0]   eng_cnt_nxt;
    logic [1:0]   eng_last;
    logic [8:0]   fir_cnt_r;
    logic [8:0]   fir_half;
    logic         fir_run;
    logic         filter_clock_r;
    logic         polarity;
    logic         alt_frame;

    assign acc.addr  = CFG_ADDR;
    assign acc.wdata = CFG_WDATA;
    assign acc.wr    = CFG_WR;
    assign acc.rd    = CFG_RD;
    assign pm        = power_mode_t'(POWER_MODE);

    // power mode edge
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            pm_prev_r <= PM_MISSION;
        end else begin
            pm_prev_r <= pm;
        end
    end

    assign enter_sleep = (pm == PM_SLEEP) && (pm_prev_r != PM_SLEEP);

    // next configuration from processor writes
    always_comb begin
        cfg_nxt = cfg_r;
        if (acc.wr) begin
            if (hit(acc.addr, OFS_ENGINE_CTRL)) begin
                cfg_nxt.engine_fast_clock_select =
                    acc.wdata[POS_FAST_CLK];
                cfg_nxt.engine_enable = acc.wdata[POS_ENGINE_EN];
            end
            if (hit(acc.addr, OFS_REF_CHOP)) begin
                cfg_nxt.chop_mode =
                    chop_mode_t'(acc.wdata[POS_CHOP_MODE +: 2]);
            end
            if (hit(acc.addr, OFS_PIN_CLK_OUT)) begin
                cfg_nxt.clock_output_select =
                    acc.wdata[POS_CLK_OUT_SEL];
            end
            if (hit(acc.addr, OFS_CONV_ENABLE)) begin
                cfg_nxt.converter_enable = acc.wdata[POS_CONV_EN];
            end
            if (hit(acc.addr, OFS_BATT_MEASURE)) begin
                cfg_nxt.battery_measure_enable =
                    acc.wdata[POS_BATT_EN];
            end
            if (hit(acc.addr, OFS_BOOT_SIZE)) begin
                cfg_nxt.boot_size = acc.wdata;
            end
            if (hit(acc.addr, OFS_PROG_LOC)) begin
                cfg_nxt.engine_program_location =
                    acc.wdata[PROG_LOC_W-1:0];
            end
            if (hit(acc.addr, OFS_CHOP_MASTER)) begin
                cfg_nxt.current_chop_master =
                    acc.wdata[POS_MASTER_EN];
            end
            if (hit(acc.addr, OFS_CHOP_CHANS)) begin
                cfg_nxt.current_a_swap_enable =
                    acc.wdata[POS_CHAN_A];
                cfg_nxt.current_b_swap_enable =
                    acc.wdata[POS_CHAN_B];
            end
        end
    end

    // configuration storage
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            cfg_r.engine_fast_clock_select <= 1'b0;
            cfg_r.engine_enable            <= 1'b0;
            cfg_r.chop_mode                <= chop_mode_t'(RST_CHOP_MODE);
            cfg_r.clock_output_select      <= 1'b0;
            cfg_r.converter_enable         <= 1'b0;
            cfg_r.battery_measure_enable   <= 1'b0;
            cfg_r.boot_size                <= RST_BOOT_SIZE;
            cfg_r.engine_program_location  <= RST_PROG_LOC;
            cfg_r.current_chop_master      <= 1'b0;
            cfg_r.current_a_swap_enable    <= 1'b0;
            cfg_r.current_b_swap_enable    <= 1'b0;
        end else if (WAKE) begin
            cfg_r.engine_fast_clock_select <= 1'b0;
            cfg_r.engine_enable            <= 1'b0;
            cfg_r.chop_mode                <= chop_mode_t'(RST_CHOP_MODE);
            cfg_r.clock_output_select      <= 1'b0;
            cfg_r.converter_enable         <= 1'b0;
            // undefined on wake: kept as is
            cfg_r.battery_measure_enable   <=
                cfg_r.battery_measure_enable;
            cfg_r.boot_size                <= WAKE_BOOT_SIZE;
            cfg_r.engine_program_location  <= WAKE_PROG_LOC;
            cfg_r.current_chop_master      <= 1'b0;
            cfg_r.current_a_swap_enable    <= 1'b0;
            cfg_r.current_b_swap_enable    <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            if (enter_sleep) begin
                // display-retained bit lost on sleep
                cfg_r.clock_output_select <= 1'b0;
            end
        end
    end

    // read data mux
    always_comb begin
        rdata_nxt = 8'h00;
        if (hit(acc.addr, OFS_ENGINE_CTRL)) begin
            rdata_nxt[POS_FAST_CLK]  = cfg_r.engine_fast_clock_select;
            rdata_nxt[POS_ENGINE_EN] = cfg_r.engine_enable;
            rdata_nxt = rd_view(rdata_nxt, WO_ENGINE_CTRL);
        end else if (hit(acc.addr, OFS_REF_CHOP)) begin
            rdata_nxt[POS_CHOP_MODE +: 2] = cfg_r.chop_mode;
            rdata_nxt = rd_view(rdata_nxt, WO_REF_CHOP);
        end else if (hit(acc.addr, OFS_PIN_CLK_OUT)) begin
            rdata_nxt[POS_CLK_OUT_SEL] = cfg_r.clock_output_select;
            rdata_nxt = rd_view(rdata_nxt, WO_PIN_CLK_OUT);
        end else if (hit(acc.addr, OFS_CONV_ENABLE)) begin
            rdata_nxt[POS_CONV_EN] = cfg_r.converter_enable;
            rdata_nxt = rd_view(rdata_nxt, WO_CONV_ENABLE);
        end else if (hit(acc.addr, OFS_BATT_MEASURE)) begin
            rdata_nxt[POS_BATT_EN] = cfg_r.battery_measure_enable;
            rdata_nxt = rd_view(rdata_nxt, WO_BATT_MEASURE);
        end else if (hit(acc.addr, OFS_BOOT_SIZE)) begin
            rdata_nxt = cfg_r.boot_size;
        end else if (hit(acc.addr, OFS_PROG_LOC)) begin
            rdata_nxt[PROG_LOC_W-1:0] = cfg_r.engine_program_location;
        end else if (hit(acc.addr, OFS_CHOP_MASTER)) begin
            rdata_nxt[POS_MASTER_EN] = cfg_r.current_chop_master;
        end else if (hit(acc.addr, OFS_CHOP_CHANS)) begin
            rdata_nxt[POS_CHAN_A] = cfg_r.current_a_swap_enable;
            rdata_nxt[POS_CHAN_B] = cfg_r.current_b_swap_enable;
        end
    end

    // registered read answer
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            CFG_RDATA <= '0;
        end else if (acc.rd) begin
            CFG_RDATA <= DATA_W'(rdata_nxt);
        end
    end

    // converter and reference enables
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            CONVERTER_ENABLE <= 1'b0;
            REFERENCE_ENABLE <= 1'b0;
        end else begin
            CONVERTER_ENABLE <= cfg_r.converter_enable;
            REFERENCE_ENABLE <= cfg_r.converter_enable;
        end
    end

    // battery measurement path
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            BATTERY_LOAD         <= 1'b0;
            BATTERY_TO_CONVERTER <= 1'b0;
        end else begin
            BATTERY_LOAD         <= cfg_r.battery_measure_enable;
            BATTERY_TO_CONVERTER <= cfg_r.battery_measure_enable
                                    & ALT_MUX_CYCLE;
        end
    end

    // boot region and engine program addresses
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            BOOT_END_ADDR     <= '0;
            ENGINE_PROG_START <= '0;
        end else begin
            BOOT_END_ADDR     <= {cfg_r.boot_size,
                                  BLOCK_SHIFT'(0)};
            ENGINE_PROG_START <= {cfg_r.engine_program_location,
                                  BLOCK_SHIFT'(0)};
        end
    end

    // engine clock enable divider
    assign eng_last = cfg_r.engine_fast_clock_select
                      ? 2'(ENG_FAST_DIV - 1)
                      : 2'(ENG_SLOW_DIV - 1);
    assign eng_cnt_nxt = (eng_cnt_r >= eng_last) ? 2'd0
                         : eng_cnt_r + 2'd1;

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            eng_cnt_r <= 2'd0;
        end else if (cfg_r.engine_enable) begin
            eng_cnt_r <= eng_cnt_nxt;
        end else begin
            eng_cnt_r <= 2'd0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ENGINE_ENABLE   <= 1'b0;
            ENGINE_CLK_TICK <= 1'b0;
        end else begin
            ENGINE_ENABLE   <= cfg_r.engine_enable;
            ENGINE_CLK_TICK <= cfg_r.engine_enable
                               && (eng_cnt_r >= eng_last);
        end
    end

    // reference chop sequencer
    chop_polarity i_chop_polarity (
        .clk        (CORE_CLK),
        .rst_n      (RESET_N),
        .sync_pulse (MULTIPLEXER_SYNC_PULSE),
        .sum_end    (SUMMATION_CYCLE_END),
        .mode       (cfg_r.chop_mode),
        .polarity   (polarity),
        .alt_frame  (alt_frame)
    );

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            REF_POLARITY              <= 1'b0;
            ALTERNATIVE_FRAME_REQUEST <= 1'b0;
        end else begin
            REF_POLARITY              <= polarity;
            ALTERNATIVE_FRAME_REQUEST <= alt_frame;
        end
    end

    // current channel chopping
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            CURRENT_A_SWAP <= 1'b0;
            CURRENT_B_SWAP <= 1'b0;
        end else begin
            CURRENT_A_SWAP <= cfg_r.current_a_swap_enable
                              & cfg_r.current_chop_master;
            CURRENT_B_SWAP <= cfg_r.current_b_swap_enable
                              & cfg_r.current_chop_master;
        end
    end

    // filter clock generator
    assign fir_half = (pm == PM_BROWNOUT) ? 9'(FIR_BRN_HALF)
                                          : 9'(FIR_MIS_HALF);
    assign fir_run  = (pm == PM_MISSION) || (pm == PM_BROWNOUT);

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            fir_cnt_r      <= 9'd0;
            filter_clock_r <= 1'b0;
        end else if (!fir_run) begin
            fir_cnt_r      <= 9'd0;
            filter_clock_r <= 1'b0;
        end else if (fir_cnt_r >= fir_half - 9'd1) begin
            fir_cnt_r      <= 9'd0;
            filter_clock_r <= ~filter_clock_r;
        end else begin
            fir_cnt_r      <= fir_cnt_r + 9'd1;
        end
    end

    // shared segment / clock pin
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            SHARED_PIN_OUT <= 1'b0;
        end else if (cfg_r.clock_output_select) begin
            SHARED_PIN_OUT <= filter_clock_r;
        end else begin
            SHARED_PIN_OUT <= DISPLAY_SEGMENT_NINETEEN;
        end
    end

endmodule : metering_config_bits

// ### shared/metering_cfg_pkg.sv
// constants and types for the metering configuration bank
package metering_cfg_pkg;

    // register offsets
    localparam logic [15:0] OFS_ENGINE_CTRL  = 16'h2000;
    localparam logic [15:0] OFS_REF_CHOP     = 16'h2002;
    localparam logic [15:0] OFS_PIN_CLK_OUT  = 16'h2004;
    localparam logic [15:0] OFS_CONV_ENABLE  = 16'h2005;
    localparam logic [15:0] OFS_BATT_MEASURE = 16'h2020;
    localparam logic [15:0] OFS_BOOT_SIZE    = 16'h20A7;
    localparam logic [15:0] OFS_PROG_LOC     = 16'h20A8;
    localparam logic [15:0] OFS_CHOP_MASTER  = 16'h20AB;
    localparam logic [15:0] OFS_CHOP_CHANS   = 16'h20AC;

    // field positions
    localparam int POS_FAST_CLK    = 3;
    localparam int POS_ENGINE_EN   = 4;
    localparam int POS_CHOP_MODE   = 4;
    localparam int POS_CLK_OUT_SEL = 4;
    localparam int POS_CONV_EN     = 3;
    localparam int POS_BATT_EN     = 6;
    localparam int POS_MASTER_EN   = 0;
    localparam int POS_CHAN_A      = 0;
    localparam int POS_CHAN_B      = 4;
    localparam int PROG_LOC_W      = 5;
    localparam int BLOCK_SHIFT     = 10;

    // write-only bits per register, read back as zero
    localparam logic [7:0] WO_ENGINE_CTRL  = 8'h00;
    localparam logic [7:0] WO_REF_CHOP     = 8'h00;
    localparam logic [7:0] WO_PIN_CLK_OUT  = 8'h00;
    localparam logic [7:0] WO_CONV_ENABLE  = 8'h00;
    localparam logic [7:0] WO_BATT_MEASURE = 8'h00;

    // reset and wake values
    localparam logic [7:0] RST_BOOT_SIZE  = 8'h01;
    localparam logic [7:0] WAKE_BOOT_SIZE = 8'h01;
    localparam logic [4:0] RST_PROG_LOC   = 5'h1F;
    localparam logic [4:0] WAKE_PROG_LOC  = 5'h1F;
    localparam logic [1:0] RST_CHOP_MODE  = 2'h0;

    // clock rates
    localparam int CORE_CLK_HZ    = 20_000_000;
    localparam int ENGINE_FAST_HZ = 10_000_000;
    localparam int ENGINE_SLOW_HZ = 5_000_000;
    localparam int FIR_MISSION_HZ = 5_000_000;
    localparam int FIR_BROWN_HZ   = 32_000;
    localparam int ENG_FAST_DIV   = CORE_CLK_HZ / ENGINE_FAST_HZ;
    localparam int ENG_SLOW_DIV   = CORE_CLK_HZ / ENGINE_SLOW_HZ;
    localparam int FIR_MIS_HALF   = CORE_CLK_HZ / (2 * FIR_MISSION_HZ);
    localparam int FIR_BRN_HALF   = CORE_CLK_HZ / (2 * FIR_BROWN_HZ);

    // power modes, gray along mission-brownout-display-sleep
    typedef enum logic [1:0] {
        PM_MISSION  = 2'b00,
        PM_BROWNOUT = 2'b01,
        PM_DISPLAY  = 2'b11,
        PM_SLEEP    = 2'b10
    } power_mode_t;

    // bandgap chop modes
    typedef enum logic [1:0] {
        CHOP_TOGGLE_ALT = 2'b00,
        CHOP_POSITIVE   = 2'b01,
        CHOP_REVERSED   = 2'b10,
        CHOP_TOGGLE     = 2'b11
    } chop_mode_t;

    // stored configuration
    typedef struct packed {
        logic       engine_fast_clock_select;
        logic       engine_enable;
        chop_mode_t chop_mode;
        logic       clock_output_select;
        logic       converter_enable;
        logic       battery_measure_enable;
        logic [7:0] boot_size;
        logic [4:0] engine_program_location;
        logic       current_chop_master;
        logic       current_a_swap_enable;
        logic       current_b_swap_enable;
    } cfg_t;

    // processor register access
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } cfg_access_t;

endpackage : metering_cfg_pkg

// ### verif/metering_config_bits_assertions.sv
// assertions for the metering configuration bank
`timescale 1ns/1ns
module metering_config_bits_assertions
    import metering_cfg_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RESET_N,
    input wire logic        WAKE,
    input wire logic [15:0] CFG_ADDR,
    input wire logic [7:0]  CFG_WDATA,
    input wire logic        CFG_WR,
    input wire logic        CFG_RD,
    input wire logic        MULTIPLEXER_SYNC_PULSE,
    input wire logic        ALT_MUX_CYCLE,
    input wire logic        DISPLAY_SEGMENT_NINETEEN,
    input wire logic [7:0]  CFG_RDATA,
    input wire logic        CONVERTER_ENABLE,
    input wire logic        REFERENCE_ENABLE,
    input wire logic        BATTERY_LOAD,
    input wire logic        BATTERY_TO_CONVERTER,
    input wire logic [17:0] BOOT_END_ADDR,
    input wire logic [14:0] ENGINE_PROG_START,
    input wire logic        ENGINE_CLK_TICK,
    input wire logic        REF_POLARITY,
    input wire logic        ALTERNATIVE_FRAME_REQUEST,
    input wire logic        CURRENT_A_SWAP,
    input wire logic        CURRENT_B_SWAP,
    input wire logic        SHARED_PIN_OUT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    wire wd_conv = CFG_WDATA[POS_CONV_EN];
    wire wr_ok   = CFG_WR && !WAKE;
    wire sync    = MULTIPLEXER_SYNC_PULSE;

    property p_conv_wr; wr_ok && CFG_ADDR == OFS_CONV_ENABLE
        |-> ##3 CONVERTER_ENABLE == $past(wd_conv, 3); endproperty
    a_conv_wr: assert property (p_conv_wr) else $error("conv");
    property p_ref; REFERENCE_ENABLE == CONVERTER_ENABLE; endproperty
    a_ref: assert property (p_ref) else $error("ref enable");
    property p_batt; BATTERY_TO_CONVERTER
        |-> BATTERY_LOAD && $past(ALT_MUX_CYCLE); endproperty
    a_batt: assert property (p_batt) else $error("battery route");
    property p_boot; wr_ok && CFG_ADDR == OFS_BOOT_SIZE
        |-> ##3 BOOT_END_ADDR == {$past(CFG_WDATA, 3), 10'h000}; endproperty
    a_boot: assert property (p_boot) else $error("boot end");
    property p_prog; wr_ok && CFG_ADDR == OFS_PROG_LOC |-> ##3
        ENGINE_PROG_START == {$past(CFG_WDATA[4:0], 3), 10'h000}; endproperty
    a_prog: assert property (p_prog) else $error("prog start");
    property p_pol; $changed(REF_POLARITY)
        |-> $past(sync, 2) && !$past(sync, 3); endproperty
    a_pol: assert property (p_pol) else $error("polarity step");
    property p_alt; ALTERNATIVE_FRAME_REQUEST |-> $past(sync, 2)
        && !$past(sync, 3) ##1 !ALTERNATIVE_FRAME_REQUEST; endproperty
    a_alt: assert property (p_alt) else $error("alt request");
    property p_unmapped; CFG_RD && !WAKE && CFG_ADDR == 16'h2001
        |=> CFG_RDATA == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmap");
    property p_swap; wr_ok && CFG_ADDR == OFS_CHOP_MASTER && !CFG_WDATA[0]
        |-> ##3 !CURRENT_A_SWAP && !CURRENT_B_SWAP; endproperty
    a_swap: assert property (p_swap) else $error("swap gate");
    property p_pin; wr_ok && CFG_ADDR == OFS_PIN_CLK_OUT && !CFG_WDATA[4]
        |-> ##3 SHARED_PIN_OUT == $past(DISPLAY_SEGMENT_NINETEEN); endproperty
    a_pin: assert property (p_pin) else $error("shared pin");
    property p_tick; ENGINE_CLK_TICK |=> !ENGINE_CLK_TICK; endproperty
    a_tick: assert property (p_tick) else $error("engine tick");
    c_alt: cover property (ALTERNATIVE_FRAME_REQUEST);
    c_batt: cover property (BATTERY_TO_CONVERTER);
    c_tick: cover property (ENGINE_CLK_TICK ##2 ENGINE_CLK_TICK);
endmodule : metering_config_bits_assertions

bind metering_config_bits metering_config_bits_assertions
    i_metering_config_bits_assertions (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .WAKE(WAKE),
    .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_WR(CFG_WR),
    .CFG_RD(CFG_RD), .MULTIPLEXER_SYNC_PULSE(MULTIPLEXER_SYNC_PULSE),
    .ALT_MUX_CYCLE(ALT_MUX_CYCLE),
    .DISPLAY_SEGMENT_NINETEEN(DISPLAY_SEGMENT_NINETEEN),
    .CFG_RDATA(CFG_RDATA), .CONVERTER_ENABLE(CONVERTER_ENABLE),
    .REFERENCE_ENABLE(REFERENCE_ENABLE), .BATTERY_LOAD(BATTERY_LOAD),
    .BATTERY_TO_CONVERTER(BATTERY_TO_CONVERTER),
    .BOOT_END_ADDR(BOOT_END_ADDR), .ENGINE_PROG_START(ENGINE_PROG_START),
    .ENGINE_CLK_TICK(ENGINE_CLK_TICK), .REF_POLARITY(REF_POLARITY),
    .ALTERNATIVE_FRAME_REQUEST(ALTERNATIVE_FRAME_REQUEST),
    .CURRENT_A_SWAP(CURRENT_A_SWAP), .CURRENT_B_SWAP(CURRENT_B_SWAP),
    .SHARED_PIN_OUT(SHARED_PIN_OUT));

// ### verif/metering_config_bits_tb.sv
// self-checking bench for the metering configuration bank
`timescale 1ns/1ns
module metering_config_bits_tb
    import metering_cfg_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wake = 1'b0, wr = 1'b0, rd = 1'b0;
    logic sync = 1'b0, sum_end = 1'b0, alt = 1'b0, seg = 1'b0;
    logic [1:0]  pm = 2'h0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [17:0] boot_end;
    logic [14:0] prog;
    logic conv, refe, bload, bconv, eng_en, tick, pol, alt_req, swa, swb, pin;
    int bad_count = 0, total_checks = 0, alt_cnt = 0, tick_cnt = 0;
    int pin_cnt = 0;

    metering_config_bits i_metering_config_bits (
        .CORE_CLK(clk), .RESET_N(rst_n), .WAKE(wake), .POWER_MODE(pm),
        .CFG_ADDR(addr), .CFG_WDATA(wdata), .CFG_WR(wr), .CFG_RD(rd),
        .MULTIPLEXER_SYNC_PULSE(sync), .SUMMATION_CYCLE_END(sum_end),
        .ALT_MUX_CYCLE(alt), .DISPLAY_SEGMENT_NINETEEN(seg),
        .CFG_RDATA(rdata), .CONVERTER_ENABLE(conv), .REFERENCE_ENABLE(refe),
        .BATTERY_LOAD(bload), .BATTERY_TO_CONVERTER(bconv),
        .BOOT_END_ADDR(boot_end), .ENGINE_PROG_START(prog),
        .ENGINE_ENABLE(eng_en), .ENGINE_CLK_TICK(tick), .REF_POLARITY(pol),
        .ALTERNATIVE_FRAME_REQUEST(alt_req), .CURRENT_A_SWAP(swa),
        .CURRENT_B_SWAP(swb), .SHARED_PIN_OUT(pin));

    always #25 clk = ~clk;
    always @(posedge alt_req) alt_cnt++;
    always @(posedge tick) tick_cnt++;
    always @(pin) pin_cnt++;

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(3);
    endtask : wr_reg

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(1);
        chk(18'(rdata), 18'(e));
    endtask : rd_chk

    task automatic step_pol(input logic e);
        sync = 1'b1;
        cyc(2);
        sync = 1'b0;
        cyc(4);
        chk(18'(pol), 18'(e));
    endtask : step_pol

    task automatic t_reset;
        chk(boot_end, 18'h0_0400);
        chk(18'(prog), 18'h0_7C00);
        rd_chk(OFS_BOOT_SIZE, 8'h01);
        rd_chk(OFS_PROG_LOC, 8'h1F);
        rd_chk(OFS_ENGINE_CTRL, 8'h00);
    endtask : t_reset

    task automatic t_regs;
        wr_reg(OFS_CONV_ENABLE, 8'h08);
        chk(18'({conv, refe}), 18'h0_0003);
        rd_chk(OFS_CONV_ENABLE, 8'h08);
        wr_reg(OFS_CONV_ENABLE, 8'h00);
        chk(18'({conv, refe}), 18'h0_0000);
        wr_reg(OFS_BOOT_SIZE, 8'hFF);
        chk(boot_end, 18'h3_FC00);
        wr_reg(OFS_PROG_LOC, 8'h00);
        chk(18'(prog), 18'h0_0000);
        wr_reg(OFS_PROG_LOC, 8'h03);
        chk(18'(prog), 18'h0_0C00);
        rd_chk(16'h2001, 8'h00);
    endtask : t_regs

    task automatic t_batt_wake;
        wr_reg(OFS_BATT_MEASURE, 8'h40);
        chk(18'(bload), 18'h0_0001);
        alt = 1'b1;
        cyc(2);
        chk(18'(bconv), 18'h0_0001);
        alt = 1'b0;
        cyc(2);
        chk(18'(bconv), 18'h0_0000);
        wr_reg(OFS_BOOT_SIZE, 8'h05);
        wake = 1'b1;
        cyc(1);
        wake = 1'b0;
        cyc(3);
        rd_chk(OFS_BOOT_SIZE, 8'h01);
        rd_chk(OFS_BATT_MEASURE, 8'h40);
    endtask : t_batt_wake

    task automatic t_engine;
        wr_reg(OFS_ENGINE_CTRL, 8'h10);
        chk(18'(eng_en), 18'h0_0001);
        tick_cnt = 0;
        cyc(40);
        chk(18'(tick_cnt), 18'h0_000A);
        wr_reg(OFS_ENGINE_CTRL, 8'h18);
        tick_cnt = 0;
        cyc(40);
        chk(18'(tick_cnt), 18'h0_0014);
    endtask : t_engine

    task automatic t_chop;
        wr_reg(OFS_REF_CHOP, 8'h10);
        step_pol(1'b0);
        wr_reg(OFS_REF_CHOP, 8'h20);
        chk(18'(pol), 18'h0_0000);
        step_pol(1'b1);
        wr_reg(OFS_REF_CHOP, 8'h30);
        alt_cnt = 0;
        step_pol(1'b0);
        step_pol(1'b1);
        chk(18'(alt_cnt), 18'h0_0000);
        wr_reg(OFS_REF_CHOP, 8'h00);
        sum_end = 1'b1;
        step_pol(1'b1);
        chk(18'(alt_cnt), 18'h0_0001);
        sum_end = 1'b0;
        step_pol(1'b0);
    endtask : t_chop

    task automatic t_swap;
        wr_reg(OFS_CHOP_CHANS, 8'h11);
        chk(18'({swa, swb}), 18'h0_0000);
        wr_reg(OFS_CHOP_MASTER, 8'h01);
        chk(18'({swa, swb}), 18'h0_0003);
        wr_reg(OFS_CHOP_CHANS, 8'h10);
        chk(18'({swa, swb}), 18'h0_0001);
        wr_reg(OFS_CHOP_MASTER, 8'h00);
        chk(18'({swa, swb}), 18'h0_0000);
    endtask : t_swap

    task automatic t_pin;
        seg = 1'b1;
        wr_reg(OFS_PIN_CLK_OUT, 8'h00);
        chk(18'(pin), 18'h0_0001);
        wr_reg(OFS_PIN_CLK_OUT, 8'h10);
        pin_cnt = 0;
        cyc(40);
        chk(18'(pin_cnt), 18'h0_0014);
        pm = 2'h1;
        cyc(2);
        pm = 2'h3;
        cyc(2);
        pm = 2'h1;
        cyc(2);
        rd_chk(OFS_PIN_CLK_OUT, 8'h10);
        pm = 2'h2;
        cyc(3);
        pm = 2'h0;
        cyc(3);
        rd_chk(OFS_PIN_CLK_OUT, 8'h00);
        chk(18'(pin), 18'h0_0001);
    endtask : t_pin

    task automatic complete_run;
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        cyc(16);
        rst_n = 1'b1;
        cyc(2);
        t_reset();
        t_regs();
        t_batt_wake();
        t_engine();
        t_chop();
        t_swap();
        t_pin();
        complete_run();
    end
endmodule : metering_config_bits_tb
